/* File: hdl/rtc_cal_defs.svh */
// offsets, field positions, reset values and limits of the calendar counters
// assumes byte-wide register access from the serial bus front end
`ifndef RTC_CAL_DEFS_SVH
`define RTC_CAL_DEFS_SVH
// ==========================================
// register offsets
`define RTC_CAL_ADDR_SEC   8'h02
`define RTC_CAL_ADDR_MIN   8'h03
`define RTC_CAL_ADDR_HOUR  8'h04
`define RTC_CAL_ADDR_DAY   8'h05
`define RTC_CAL_ADDR_WDAY  8'h06
`define RTC_CAL_ADDR_MON   8'h07
`define RTC_CAL_ADDR_YEAR  8'h08
// ==========================================
// field positions
`define RTC_CAL_VL_BIT     7
`define RTC_CAL_CENT_BIT   7
// ==========================================
// reset values
`define RTC_CAL_RST_VL     1'b1
`define RTC_CAL_RST_SEC    7'h00
`define RTC_CAL_RST_MIN    7'h00
`define RTC_CAL_RST_HOUR   6'h00
`define RTC_CAL_RST_DAY    6'h01
`define RTC_CAL_RST_WDAY   3'h0
`define RTC_CAL_RST_CENT   1'b0
`define RTC_CAL_RST_MON    5'h01
`define RTC_CAL_RST_YEAR   8'h00
// ==========================================
// counting limits, bcd
`define RTC_CAL_MAX_SEC    7'h59
`define RTC_CAL_MAX_MIN    7'h59
`define RTC_CAL_MAX_HOUR   6'h23
`define RTC_CAL_MAX_WDAY   3'h6
`define RTC_CAL_MAX_MON    5'h12
`define RTC_CAL_MAX_YEAR   8'h99
`define RTC_CAL_MON_FEB    5'h02
`define RTC_CAL_DAYS_31    6'h31
`define RTC_CAL_DAYS_30    6'h30
`define RTC_CAL_DAYS_FEB   6'h28
`define RTC_CAL_DAYS_LEAP  6'h29
`endif

/* File: hdl/rtc_cal_pkg.sv */
// types shared by the calendar counter block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package rtc_cal_pkg;
	// ==========================================
	// time of day and calendar state
	typedef struct packed {
		logic       vl;
		logic [6:0] sec;
		logic [6:0] min;
		logic [5:0] hour;
		logic [5:0] day;
		logic [2:0] wday;
		logic       cent;
		logic [4:0] mon;
		logic [7:0] year;
	} rtc_cal_time_s;
	// ==========================================
	// one register access from the bus front end
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtc_cal_acc_s;
endpackage
`default_nettype wire

/* File: hdl/rtc_cal_counters.sv */
// bcd time and calendar counters with integrity flag and century flag
// assumes a bus front end that presents byte accesses and flags an access in progress
`include "rtc_cal_defs.svh"
`default_nettype none
module rtc_cal_counters (
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      tick_1hz_i,
	input  wire logic                      supply_low_i,
	input  wire logic                      osc_stopped_i,
	input  wire logic                      acc_busy_i,
	input  wire rtc_cal_pkg::rtc_cal_acc_s acc_i,
	output logic                    [7:0]  rdata_o,
	output logic                           integrity_lost_o,
	output logic                           century_o
);
	// ==========================================
	// helpers
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = {v[7:4], v[3:0] + 4'h1};
		return r;
	endfunction

	// bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
	function automatic logic is_leap(input logic [7:0] y);
		logic u;
		u = 1'b0;
		if (y[4] == 1'b0)
			u = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		else
			u = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		return u;
	endfunction

	function automatic logic [5:0] last_day(input logic [4:0] m, input logic leap);
		logic [5:0] d;
		d = `RTC_CAL_DAYS_31;
		case (m)
			`RTC_CAL_MON_FEB: d = leap ? `RTC_CAL_DAYS_LEAP : `RTC_CAL_DAYS_FEB;
			5'h04, 5'h06, 5'h09, 5'h11: d = `RTC_CAL_DAYS_30;
			default: d = `RTC_CAL_DAYS_31;
		endcase
		return d;
	endfunction

	// ==========================================
	// state
	rtc_cal_pkg::rtc_cal_time_s t_r;
	rtc_cal_pkg::rtc_cal_time_s t_nxt;
	logic                       pend_r;
	logic                       pend_nxt;
	logic [7:0]                 rdata_r;
	logic [7:0]                 rdata_nxt;
	logic                       inc;
	logic                       c_min;
	logic                       c_hour;
	logic                       c_day;
	logic                       c_mon;
	logic                       c_year;
	logic                       c_cent;
	logic                       leap;

	// ==========================================
	// counting, writes and flags
	always_comb
	begin
		t_nxt  = t_r;
		c_min  = 1'b0;
		c_hour = 1'b0;
		c_day  = 1'b0;
		c_mon  = 1'b0;
		c_year = 1'b0;
		c_cent = 1'b0;
		leap   = is_leap(t_r.year);
		// a write counts as an access too, so counting never races a load
		inc = !acc_busy_i && !acc_i.wr && (tick_1hz_i || pend_r);
		// only one tick can wait; a second one during the same access is lost
		if (acc_busy_i || acc_i.wr)
			pend_nxt = pend_r || tick_1hz_i;
		else
			pend_nxt = pend_r && tick_1hz_i;
		if (inc)
		begin
			if (t_r.sec == `RTC_CAL_MAX_SEC)
			begin
				t_nxt.sec = `RTC_CAL_RST_SEC;
				c_min     = 1'b1;
			end
			else
				t_nxt.sec = 7'(bcd_inc({1'b0, t_r.sec}));
		end
		if (c_min)
		begin
			if (t_r.min == `RTC_CAL_MAX_MIN)
			begin
				t_nxt.min = `RTC_CAL_RST_MIN;
				c_hour    = 1'b1;
			end
			else
				t_nxt.min = 7'(bcd_inc({1'b0, t_r.min}));
		end
		if (c_hour)
		begin
			if (t_r.hour == `RTC_CAL_MAX_HOUR)
			begin
				t_nxt.hour = `RTC_CAL_RST_HOUR;
				c_day      = 1'b1;
			end
			else
				t_nxt.hour = 6'(bcd_inc({2'b00, t_r.hour}));
		end
		if (c_day)
		begin
			if (t_r.wday == `RTC_CAL_MAX_WDAY)
				t_nxt.wday = `RTC_CAL_RST_WDAY;
			else
				t_nxt.wday = t_r.wday + 3'h1;
			if (t_r.day == last_day(t_r.mon, leap))
			begin
				t_nxt.day = `RTC_CAL_RST_DAY;
				c_mon     = 1'b1;
			end
			else
				t_nxt.day = 6'(bcd_inc({2'b00, t_r.day}));
		end
		if (c_mon)
		begin
			if (t_r.mon == `RTC_CAL_MAX_MON)
			begin
				t_nxt.mon = `RTC_CAL_RST_MON;
				c_year    = 1'b1;
			end
			else
				t_nxt.mon = 5'(bcd_inc({3'b000, t_r.mon}));
		end
		if (c_year)
		begin
			if (t_r.year == `RTC_CAL_MAX_YEAR)
			begin
				t_nxt.year = `RTC_CAL_RST_YEAR;
				c_cent     = 1'b1;
			end
			else
				t_nxt.year = bcd_inc(t_r.year);
		end
		if (c_cent)
			t_nxt.cent = !t_r.cent;
		// unused bit positions are simply not stored
		if (acc_i.wr)
		begin
			case (acc_i.addr)
				`RTC_CAL_ADDR_SEC:
				begin
					t_nxt.vl  = acc_i.wdata[`RTC_CAL_VL_BIT];
					t_nxt.sec = acc_i.wdata[6:0];
				end
				`RTC_CAL_ADDR_MIN:  t_nxt.min  = acc_i.wdata[6:0];
				`RTC_CAL_ADDR_HOUR: t_nxt.hour = acc_i.wdata[5:0];
				`RTC_CAL_ADDR_DAY:  t_nxt.day  = acc_i.wdata[5:0];
				`RTC_CAL_ADDR_WDAY: t_nxt.wday = acc_i.wdata[2:0];
				`RTC_CAL_ADDR_MON:
				begin
					t_nxt.cent = acc_i.wdata[`RTC_CAL_CENT_BIT];
					t_nxt.mon  = acc_i.wdata[4:0];
				end
				`RTC_CAL_ADDR_YEAR: t_nxt.year = acc_i.wdata;
				default: t_nxt.vl = t_nxt.vl;
			endcase
		end
		// a detector event in the clearing cycle wins over the clear
		if (supply_low_i || osc_stopped_i)
			t_nxt.vl = 1'b1;
	end

	// ==========================================
	// read data, one cycle after the address
	always_comb
	begin
		case (acc_i.addr)
			`RTC_CAL_ADDR_SEC:  rdata_nxt = {t_r.vl, t_r.sec};
			`RTC_CAL_ADDR_MIN:  rdata_nxt = {1'b0, t_r.min};
			`RTC_CAL_ADDR_HOUR: rdata_nxt = {2'b00, t_r.hour};
			`RTC_CAL_ADDR_DAY:  rdata_nxt = {2'b00, t_r.day};
			`RTC_CAL_ADDR_WDAY: rdata_nxt = {5'h00, t_r.wday};
			`RTC_CAL_ADDR_MON:  rdata_nxt = {t_r.cent, 2'b00, t_r.mon};
			`RTC_CAL_ADDR_YEAR: rdata_nxt = t_r.year;
			default:            rdata_nxt = 8'h00;
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			t_r.vl   <= `RTC_CAL_RST_VL;
			t_r.sec  <= `RTC_CAL_RST_SEC;
			t_r.min  <= `RTC_CAL_RST_MIN;
			t_r.hour <= `RTC_CAL_RST_HOUR;
			t_r.day  <= `RTC_CAL_RST_DAY;
			t_r.wday <= `RTC_CAL_RST_WDAY;
			t_r.cent <= `RTC_CAL_RST_CENT;
			t_r.mon  <= `RTC_CAL_RST_MON;
			t_r.year <= `RTC_CAL_RST_YEAR;
			pend_r   <= 1'b0;
			rdata_r  <= 8'h00;
		end
		else
		begin
			t_r     <= t_nxt;
			pend_r  <= pend_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o          = rdata_r;
	assign integrity_lost_o = t_r.vl;
	assign century_o        = t_r.cent;

	// ==========================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_VL_SET: assert property (
		supply_low_i |=> integrity_lost_o)
		else $error("supply low did not set the integrity flag");

	AST_VL_OSC: assert property (
		osc_stopped_i |=> integrity_lost_o)
		else $error("oscillator stop did not set the integrity flag");

	AST_VL_STICKY: assert property (
		t_r.vl && !(acc_i.wr && acc_i.addr == `RTC_CAL_ADDR_SEC) |=> t_r.vl)
		else $error("integrity flag cleared without a bus write");

	AST_SEC_WRAP: assert property (
		inc && t_r.sec == `RTC_CAL_MAX_SEC |=> t_r.sec == 7'h00 && $changed(t_r.min))
		else $error("seconds did not wrap with a minute carry");

	AST_SEC_STEP: assert property (
		inc && t_r.sec == 7'h09 |=> t_r.sec == 7'h10)
		else $error("seconds units did not carry into tens");

	AST_HOLD: assert property (
		acc_busy_i && !acc_i.wr |=> $stable({t_r.sec, t_r.min, t_r.hour, t_r.day, t_r.year}))
		else $error("counters moved during an access");

	AST_PEND: assert property (
		acc_busy_i && tick_1hz_i ##1 !acc_busy_i && !acc_i.wr && !tick_1hz_i
		|=> !pend_r && $past(t_r.sec, 1) != t_r.sec)
		else $error("pending tick was not applied after the access");

	AST_LEAP: assert property (
		c_day && t_r.mon == `RTC_CAL_MON_FEB && t_r.day == 6'h28 && is_leap(t_r.year)
		|=> t_r.day == 6'h29 && t_r.mon == `RTC_CAL_MON_FEB)
		else $error("leap year did not allow day 29");

	AST_WDAY: assert property (
		c_day && t_r.wday == `RTC_CAL_MAX_WDAY |=> t_r.wday == 3'h0)
		else $error("weekday did not wrap to zero");

	AST_MON: assert property (
		c_mon && t_r.mon == `RTC_CAL_MAX_MON |=> t_r.mon == 5'h01 && t_r.day == 6'h01)
		else $error("december did not roll to january");

	AST_CENT: assert property (
		c_year && t_r.year == `RTC_CAL_MAX_YEAR |=> t_r.year == 8'h00 && century_o != $past(century_o))
		else $error("century flag did not toggle on year overflow");

	AST_UNUSED: assert property (
		acc_i.addr == `RTC_CAL_ADDR_HOUR |=> rdata_o[7:6] == 2'b00)
		else $error("unused hours bits read nonzero");

	AST_VL_CLR: assert property (
		acc_i.wr && acc_i.addr == `RTC_CAL_ADDR_SEC && !acc_i.wdata[`RTC_CAL_VL_BIT] && !supply_low_i && !osc_stopped_i |=> !integrity_lost_o)
		else $error("bus write of zero did not clear the integrity flag");

	AST_MIN_WRAP: assert property (
		c_min && t_r.min == `RTC_CAL_MAX_MIN |=> t_r.min == 7'h00 && $changed(t_r.hour))
		else $error("minutes did not wrap with an hour carry");

	AST_HOUR_WRAP: assert property (
		c_hour && t_r.hour == `RTC_CAL_MAX_HOUR |=> t_r.hour == 6'h00 && $changed(t_r.day))
		else $error("hours did not wrap with a day carry");

	AST_FEB_END: assert property (
		c_day && t_r.mon == `RTC_CAL_MON_FEB && t_r.day == 6'h28 && !is_leap(t_r.year) |=> t_r.day == 6'h01 && t_r.mon == 5'h03)
		else $error("common year february did not end on day 28");

	AST_WDAY_STEP: assert property (
		c_day && t_r.wday < `RTC_CAL_MAX_WDAY |=> t_r.wday == $past(t_r.wday) + 3'h1)
		else $error("weekday did not advance with the day");

	AST_YEAR_STEP: assert property (
		c_year && t_r.year != `RTC_CAL_MAX_YEAR |=> $changed(t_r.year) && $stable(t_r.cent))
		else $error("year did not step without a century toggle");

	AST_RD_SEC: assert property (
		acc_i.addr == `RTC_CAL_ADDR_SEC |=> rdata_o == {$past(t_r.vl), $past(t_r.sec)})
		else $error("seconds read did not show the flag and count");

	AST_RD_MON: assert property (
		acc_i.addr == `RTC_CAL_ADDR_MON |=> rdata_o[6:5] == 2'b00 && rdata_o[7] == $past(century_o))
		else $error("month read layout wrong");

	AST_RD_WDAY: assert property (
		acc_i.addr == `RTC_CAL_ADDR_WDAY |=> rdata_o[7:3] == 5'h00)
		else $error("unused weekday bits read nonzero");

	COV_YEAR: cover property (c_cent);
	COV_PEND: cover property (acc_busy_i && tick_1hz_i ##[1:20] inc);
	COV_LEAP: cover property (c_day && t_r.mon == `RTC_CAL_MON_FEB && t_r.day == 6'h29);
	COV_VL:   cover property (t_r.vl ##1 !t_r.vl);

endmodule // rtc_cal_counters
`default_nettype wire

/* File: dv/rtc_cal_host_model.sv */
// bus host model: one register access per request, framed by busy
// assumes a new request only after done_o of the previous one
`default_nettype none
module rtc_cal_host_model (
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      go_i,
	input  wire rtc_cal_pkg::rtc_cal_acc_s cmd_i,
	input  wire logic [7:0]                rdata_i,
	output var rtc_cal_pkg::rtc_cal_acc_s  acc_o,
	output logic                           busy_o,
	output logic                           done_o,
	output logic [7:0]                     rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] st_r;
	// ==========================================
	// access sequencer
	// four cycles per access, far inside one second
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r   <= 2'h0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			acc_o  <= '0;
			rd_o   <= 8'h00;
		end
		else
		begin
			done_o   <= 1'b0;
			acc_o.wr <= 1'b0;
			case (st_r)
				2'h0: if (go_i)
				begin
					acc_o  <= cmd_i;
					busy_o <= 1'b1;
					st_r   <= 2'h1;
				end
				2'h3:
				begin
					rd_o        <= rdata_i;
					busy_o      <= 1'b0;
					done_o      <= 1'b1;
					// released lines do not keep the last value
					acc_o.addr  <= ~acc_o.addr;
					acc_o.wdata <= ~acc_o.wdata;
					st_r        <= 2'h0;
				end
				default: st_r <= st_r + 2'h1;
			endcase
		end
	end
endmodule // rtc_cal_host_model
`default_nettype wire

/* File: dv/test_rtc_calendar_counters.sv */
// self-checking bench for the calendar counters
// assumes the host model as bus partner and a 50 MHz clock
`default_nettype none
module test_rtc_calendar_counters;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clk_i, rst_n_i, tick, low, osc, go, done, busy, integ, cent;
	rtc_cal_pkg::rtc_cal_acc_s cmd, acc;
	logic [7:0]                rdata, rd, r;
	logic [39:0]               e;
	int                        num_errors, tests_run;
	logic [7:0]  ua [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0a};
	logic [7:0]  ue [6] = '{8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h9f, 8'h00};
	logic [7:0]  sv [7] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99};
	logic [7:0]  ev [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00};
	// year, month, day, expected day, expected month
	logic [39:0] lt [5] = '{40'h0402282902, 40'h0102280103, 40'h0002282902,
		40'h0404300105, 40'h0412310101};
	rtc_cal_counters u_rtc_cal_counters (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tick_1hz_i(tick), .supply_low_i(low), .osc_stopped_i(osc), .acc_busy_i(busy),
		.acc_i(acc), .rdata_o(rdata), .integrity_lost_o(integ), .century_o(cent));
	rtc_cal_host_model u_rtc_cal_host_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go),
		.cmd_i(cmd), .rdata_i(rdata), .acc_o(acc), .busy_o(busy), .done_o(done), .rd_o(rd));
	// ==========================================
	// tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		tests_run++;
		if (g !== x)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic acc_do(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge clk_i) go <= 1'b1;
		cmd <= {w, a, d};
		@(posedge clk_i) go <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < 20);
		if (n >= 20) chk(8'h01, 8'h00);
		q = rd;
	endtask
	task automatic tk;
		@(posedge clk_i) tick <= 1'b1;
		@(posedge clk_i) tick <= 1'b0;
	endtask
	task automatic complete_run;
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================
	// clock, watchdog, tests
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		complete_run;
	end
	initial
	begin
		{rst_n_i, tick, low, osc, go} = 5'h00;
		cmd = '0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		chk({7'h00, integ}, 8'h01);
		chk({7'h00, cent}, 8'h00);
		acc_do(1'b0, 8'h02, 8'h00, r); chk(r, 8'h80);
		acc_do(1'b1, 8'h02, 8'h00, r); chk(r, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk_i) {low, osc} <= (k == 0) ? 2'b10 : 2'b01;
			@(posedge clk_i) {low, osc} <= 2'b00;
			repeat (3) @(posedge clk_i);
			acc_do(1'b0, 8'h02, 8'h00, r); chk(r, 8'h80);
			acc_do(1'b1, 8'h02, 8'h00, r); chk({7'h00, integ}, 8'h00);
		end
		for (int k = 0; k < 6; k++)
		begin
			acc_do(1'b1, ua[k], 8'hff, r); chk(r, ue[k]);
		end
		for (int k = 0; k < 7; k++) acc_do(1'b1, 8'(k + 2), sv[k], r);
		tk;
		for (int k = 0; k < 7; k++)
		begin
			acc_do(1'b0, 8'(k + 2), 8'h00, r); chk(r, ev[k]);
		end
		chk({7'h00, cent}, 8'h01);
		for (int k = 0; k < 5; k++)
		begin
			e = lt[k];
			acc_do(1'b1, 8'h02, 8'h59, r);
			acc_do(1'b1, 8'h03, 8'h59, r);
			acc_do(1'b1, 8'h04, 8'h23, r);
			acc_do(1'b1, 8'h05, e[23:16], r);
			acc_do(1'b1, 8'h07, e[31:24], r);
			acc_do(1'b1, 8'h08, e[39:32], r);
			tk;
			acc_do(1'b0, 8'h05, 8'h00, r); chk(r, e[15:8]);
			acc_do(1'b0, 8'h07, 8'h00, r); chk(r, e[7:0]);
		end
		acc_do(1'b1, 8'h02, 8'h09, r);
		tk;
		acc_do(1'b0, 8'h02, 8'h00, r); chk(r, 8'h10);
		// two ticks inside one access: only one may survive
		fork
			acc_do(1'b0, 8'h02, 8'h00, r);
			begin
				@(posedge clk_i);
				tk;
				tk;
			end
		join
		chk(r, 8'h10);
		acc_do(1'b0, 8'h02, 8'h00, r); chk(r, 8'h11);
		complete_run;
	end
endmodule // test_rtc_calendar_counters
`default_nettype wire
